// ===== common/char_link_if.sv
// Carries one received character from the handshake to the decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps

interface char_link_if;
  logic       valid;
  logic [6:0] code;
  logic       data_mode;

  modport src (output valid, output code, output data_mode);
  modport dst (input valid, input code, input data_mode);
endinterface : char_link_if

// ===== common/relay_decoder_params.svh
// Named constants of the bus relay command decoder.
// Assumes inclusion by bare name from files that need codes or offsets.
`ifndef RELAY_DECODER_PARAMS_SVH
`define RELAY_DECODER_PARAMS_SVH

`define RELAY_COUNT      6
`define CODE_UNLISTEN    7'h3f
`define CODE_LOCKOUT     7'h11
`define CODE_STATE_A     7'h41
`define CODE_STATE_B     7'h42
`define CODE_SEL_FIRST   7'h31
`define CODE_SEL_LAST    7'h36
`define CODE_ADDR_TOP    2'h1
`define ADDR_RESERVED    5'h1f

`define OFS_CONTROL      8'h00
`define OFS_STATUS       8'h04
`define OFS_COUNT        8'h08
`define CONTROL_RESET    1'h1
`define ST_LISTEN        0
`define ST_REMOTE        1
`define ST_LOCKOUT       2
`define ST_PEND          3
`define ST_PEND_A        4
`define ST_RELAY_LSB     8

`endif

// ===== common/relay_decoder_pkg.sv
// Types shared by the decoder and its character handshake.
// Assumes the constants header is available on the include path.
`include "relay_decoder_params.svh"

package relay_decoder_pkg;

  typedef enum logic [1:0] {
    HS_IDLE    = 2'b00,
    HS_HELD    = 2'b01,
    HS_RELEASE = 2'b11
  } hs_state_e;

  typedef logic [`RELAY_COUNT-1:0] relay_t;

  typedef struct packed {
    logic       dav_s1;
    logic       dav_s2;
    logic [6:0] dio_s1;
    logic [6:0] dio_s2;
    logic       mre_s1;
    logic       mre_s2;
    hs_state_e  state;
    logic       ready_for_data_line;
    logic       dac;
    logic       valid;
    logic [6:0] code;
    logic       data_mode;
  } hs_s;

  typedef struct packed {
    logic        ren_s1;
    logic        ren_s2;
    logic        eop_s1;
    logic        eop_s2;
    logic        lrs_s1;
    logic        lrs_s2;
    logic [4:0]  adr_s1;
    logic [4:0]  adr_s2;
    relay_t      pnl_s1;
    relay_t      pnl_s2;
    logic        listener_flag;
    logic        remote;
    logic        lockout;
    logic        pend_valid;
    logic        pend_a;
    relay_t      relay;
    logic        enable;
    logic [15:0] count;
    logic        a_sel;
    logic        a_write;
    logic [7:0]  a_addr;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
  } dec_s;

endpackage : relay_decoder_pkg

// ===== src/bus_relay_command_decoder.sv
// Listener-side command decoder for a six-relay bus-controlled actuator.
// Assumes an AHB-Lite master on CLOCK; all bus and panel pins are async.
//
// Notes on behaviour
// - Unlisten with remote enable high clears listener.
// - Own address, enable low, sets listener flag.
// - Address match uses the five address switches.
// - Any other command character except lockout clears listener flag.
// - Lockout command disables the return-to-local switch.
// - Remote enable high releases local lockout.
// - Own address with enable low enters remote.
// - Entering remote keeps relays as under local.
// - Leaving remote sets relays from panel switches.
// - Remote enable high returns local, lamp off.
// - Code A arms A-to-common connection.
// - Code B arms B-to-common connection.
// - Digits one to six set that relay.
// - Relay indicator lit for A, dark for B.
// - Armed state persists over several selects.
// - Command-mode line low means bus command.
// - End-of-program clears listener, stays remote.
// - Data valid paced by ready and accepted lines.
// - Return-to-local switch works unless locked out.
`timescale 1ns/100ps
`include "relay_decoder_params.svh"

module bus_relay_command_decoder #(
  parameter int RELAYS = `RELAY_COUNT
) (
  input  wire logic                          CLOCK,
  input  wire logic                          ARST_N,
  input  wire logic                          HSEL,
  input  wire logic [31:0]                   HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic [31:0]                   HWDATA,
  input  wire logic                          HREADY,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  output logic [31:0]                        HRDATA,
  input  wire logic [6:0]                    DATA_LINES,
  input  wire logic                          DATA_VALID,
  output logic                               READY_FOR_DATA_LINE,
  output logic                               DATA_ACCEPTED,
  input  wire logic                          COMMAND_MODE_LINE,
  input  wire logic                          REMOTE_ENABLE,
  input  wire logic                          END_OF_PROGRAM_LINE_N,
  input  wire logic                          LOCAL_RESET_SWITCH,
  input  wire logic [4:0]                    ADDRESS_SWITCHES,
  input  wire relay_decoder_pkg::relay_t     PANEL_SWITCHES,
  output relay_decoder_pkg::relay_t          RELAY_TO_A,
  output relay_decoder_pkg::relay_t          RELAY_LAMPS,
  output logic                               REMOTE_LAMP
);
  import relay_decoder_pkg::*;

  // ****************************************************************
  // Elaboration checks.
  // ****************************************************************
  // Select codes exist only for digits one to six.
  if (RELAYS != `RELAY_COUNT) begin : g_bad_relays
    $error("RELAYS must equal the six select codes");
  end

  dec_s        s_reg;
  dec_s        s_next;
  char_link_if link ();

  char_handshake u_handshake (
    .clock   (CLOCK),
    .arst_n  (ARST_N),
    .dav_pin (DATA_VALID),
    .dio_pin (DATA_LINES),
    .mre_pin (COMMAND_MODE_LINE),
    .ready_for_data_line     (READY_FOR_DATA_LINE),
    .dac     (DATA_ACCEPTED),
    .link    (link)
  );

  // ****************************************************************
  // Character classification.
  // ****************************************************************
  logic       ren_high;
  logic       eop_active;
  logic       addr_legal;
  logic [6:0] own_addr;
  logic       cmd_char;
  logic       data_char;
  logic       is_select;
  logic [6:0] sel_offset;
  logic [2:0] sel_index;
  logic       bus_phase;

  assign ren_high   = s_reg.ren_s2;
  assign eop_active = !s_reg.eop_s2;
  assign own_addr   = {`CODE_ADDR_TOP, s_reg.adr_s2};
  assign addr_legal = s_reg.adr_s2 != `ADDR_RESERVED;
  assign cmd_char   = link.valid && !link.data_mode && s_reg.enable;
  assign data_char  = link.valid && link.data_mode && s_reg.enable;
  assign is_select  = link.code >= `CODE_SEL_FIRST &&
                      link.code <= `CODE_SEL_LAST;
  assign sel_offset = link.code - `CODE_SEL_FIRST;
  assign sel_index  = sel_offset[2:0];
  assign bus_phase  = HSEL && HTRANS[1] && HREADY;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_next        = s_reg;
    s_next.ren_s1 = REMOTE_ENABLE;
    s_next.ren_s2 = s_reg.ren_s1;
    s_next.eop_s1 = END_OF_PROGRAM_LINE_N;
    s_next.eop_s2 = s_reg.eop_s1;
    s_next.lrs_s1 = LOCAL_RESET_SWITCH;
    s_next.lrs_s2 = s_reg.lrs_s1;
    s_next.adr_s1 = ADDRESS_SWITCHES;
    s_next.adr_s2 = s_reg.adr_s1;
    s_next.pnl_s1 = PANEL_SWITCHES;
    s_next.pnl_s2 = s_reg.pnl_s1;

    // Bus command decoding.
    if (cmd_char) begin
      if (link.code == own_addr && addr_legal) begin
        if (!ren_high) begin
          s_next.listener_flag = 1'b1;
          s_next.remote        = 1'b1;
        end
      end else if (link.code == `CODE_LOCKOUT) begin
        // Lockout leaves addressing alone so data may follow it.
        if (!ren_high) begin
          s_next.lockout = 1'b1;
        end
      end else begin
        s_next.listener_flag = 1'b0;
      end
    end

    // Relay data decoding.
    if (data_char && s_reg.listener_flag && s_reg.remote) begin
      if (link.code == `CODE_STATE_A) begin
        s_next.pend_valid = 1'b1;
        s_next.pend_a     = 1'b1;
      end else if (link.code == `CODE_STATE_B) begin
        s_next.pend_valid = 1'b1;
        s_next.pend_a     = 1'b0;
      end else if (is_select && s_reg.pend_valid) begin
        s_next.relay[sel_index] = s_reg.pend_a;
      end
    end

    // The end-of-program line wins over a same-cycle address.
    if (eop_active) begin
      s_next.listener_flag = 1'b0;
    end
    if (s_reg.lrs_s2 && !s_reg.lockout) begin
      s_next.remote = 1'b0;
    end
    if (ren_high) begin
      s_next.remote  = 1'b0;
      s_next.lockout = 1'b0;
    end
    if (!s_next.remote) begin
      s_next.relay      = s_reg.pnl_s2;
      s_next.pend_valid = 1'b0;
    end

    // Counter increment wins over a same-cycle software clear.
    if (s_reg.a_sel && s_reg.a_write) begin
      unique case (s_reg.a_addr)
        `OFS_CONTROL: s_next.enable = HWDATA[0];
        `OFS_COUNT:   s_next.count  = '0;
        default:      s_next.enable = s_reg.enable;
      endcase
    end
    if (link.valid) begin
      s_next.count = s_reg.count + 16'h0001;
    end

    // AHB-Lite slave, zero wait states.
    s_next.hready  = 1'b1;
    s_next.hresp   = 1'b0;
    s_next.a_sel   = bus_phase;
    s_next.a_write = HWRITE;
    s_next.a_addr  = HADDR[7:0];
    if (bus_phase && !HWRITE) begin
      unique case (HADDR[7:0])
        `OFS_CONTROL: s_next.hrdata = {31'h0, s_next.enable};
        `OFS_STATUS: begin
          s_next.hrdata = '0;
          s_next.hrdata[`ST_LISTEN]  = s_next.listener_flag;
          s_next.hrdata[`ST_REMOTE]  = s_next.remote;
          s_next.hrdata[`ST_LOCKOUT] = s_next.lockout;
          s_next.hrdata[`ST_PEND]    = s_next.pend_valid;
          s_next.hrdata[`ST_PEND_A]  = s_next.pend_a;
          s_next.hrdata[`ST_RELAY_LSB +: `RELAY_COUNT] = s_next.relay;
        end
        `OFS_COUNT:   s_next.hrdata = {16'h0, s_next.count};
        default:      s_next.hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg        <= '0;
      s_reg.eop_s1 <= 1'b1;
      s_reg.eop_s2 <= 1'b1;
      s_reg.ren_s1 <= 1'b1;
      s_reg.ren_s2 <= 1'b1;
      s_reg.enable <= `CONTROL_RESET;
      s_reg.hready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign HREADYOUT   = s_reg.hready;
  assign HRESP       = s_reg.hresp;
  assign HRDATA      = s_reg.hrdata;
  assign RELAY_TO_A  = s_reg.relay;
  assign RELAY_LAMPS = s_reg.relay;
  assign REMOTE_LAMP = s_reg.remote;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  unlisten_clears_a: assert property (
    cmd_char && link.code == `CODE_UNLISTEN && ren_high
    |=> !s_reg.listener_flag)
    else $error("unlisten left listener set");

  address_listens_a: assert property (
    cmd_char && link.code == own_addr && addr_legal && !ren_high &&
    !eop_active |=> s_reg.listener_flag && REMOTE_LAMP)
    else $error("own address not accepted");

  reserved_addr_a: assert property (
    cmd_char && !addr_legal && !s_reg.listener_flag
    |=> !s_reg.listener_flag)
    else $error("reserved address accepted");

  mismatch_clears_a: assert property (
    cmd_char && link.code != own_addr && link.code != `CODE_LOCKOUT
    |=> !s_reg.listener_flag)
    else $error("foreign command kept listener");

  lockout_sets_a: assert property (
    cmd_char && link.code == `CODE_LOCKOUT && !ren_high
    |=> s_reg.lockout ##1 (s_reg.lockout || $past(ren_high)))
    else $error("lockout not taken");

  ren_releases_a: assert property (
    ren_high |=> !s_reg.lockout && !REMOTE_LAMP)
    else $error("remote enable high did not return local");

  local_follows_a: assert property (
    !s_reg.remote ##1 !s_reg.remote |-> RELAY_TO_A == $past(s_reg.pnl_s2))
    else $error("relays not following panel in local");

  entry_holds_a: assert property (
    $rose(s_reg.remote) |-> RELAY_TO_A == $past(s_reg.pnl_s2, 2) ||
    RELAY_TO_A == $past(RELAY_TO_A))
    else $error("relays changed on entering remote");

  select_sets_a: assert property (
    data_char && s_reg.listener_flag && s_reg.remote && s_reg.pend_valid &&
    is_select && !ren_high && !(s_reg.lrs_s2 && !s_reg.lockout)
    |=> RELAY_LAMPS[$past(sel_index)] == $past(s_reg.pend_a) &&
        s_reg.pend_valid)
    else $error("relay select not applied");

  orphan_select_a: assert property (
    data_char && !s_reg.pend_valid && is_select && s_reg.remote &&
    !ren_high && !(s_reg.lrs_s2 && !s_reg.lockout)
    |=> RELAY_TO_A == $past(RELAY_TO_A))
    else $error("unarmed select changed a relay");

  eop_clears_a: assert property (
    eop_active && s_reg.remote && !ren_high && s_reg.lockout
    |=> !s_reg.listener_flag && REMOTE_LAMP)
    else $error("end of program handling wrong");

  local_switch_a: assert property (
    s_reg.lrs_s2 && !s_reg.lockout |=> !REMOTE_LAMP)
    else $error("return-to-local switch ignored");

  // ****************************************************************
  // Checks on programming and addressing.
  // ****************************************************************
  // True when nothing on the control pins forces local control back in
  // this cycle, so a remote-side effect can be checked on its own.
  logic stay_remote;
  assign stay_remote = !ren_high && !(s_reg.lrs_s2 && !s_reg.lockout);

  state_a_arms_a: assert property (
    data_char && s_reg.listener_flag && s_reg.remote && stay_remote &&
    link.code == `CODE_STATE_A
    |=> s_reg.pend_valid && s_reg.pend_a)
    else $error("state code A not recorded");

  state_b_arms_a: assert property (
    data_char && s_reg.listener_flag && s_reg.remote && stay_remote &&
    link.code == `CODE_STATE_B
    |=> s_reg.pend_valid && !s_reg.pend_a)
    else $error("state code B not recorded");

  // A unit that is not listening must neither move relays nor re-arm.
  deaf_data_a: assert property (
    data_char && s_reg.remote && !s_reg.listener_flag && stay_remote
    |=> $stable(RELAY_TO_A) && $stable(s_reg.pend_valid))
    else $error("data acted on while not listening");

  local_disarms_a: assert property (
    !s_reg.remote |-> !s_reg.pend_valid)
    else $error("armed state kept in local");

  remote_by_address_a: assert property (
    $rose(s_reg.remote) |->
    $past(cmd_char && link.code == own_addr && addr_legal && !ren_high))
    else $error("remote entered without own address");

  // Address and lockout are only heard with remote enable low.
  ren_blocks_address_a: assert property (
    cmd_char && link.code == own_addr && ren_high && !eop_active
    |=> s_reg.listener_flag == $past(s_reg.listener_flag))
    else $error("address taken with remote enable high");

  lockout_keeps_listen_a: assert property (
    cmd_char && link.code == `CODE_LOCKOUT
    |=> s_reg.listener_flag == $past(s_reg.listener_flag) ||
        $past(eop_active))
    else $error("lockout changed the listener flag");

  eop_beats_address_a: assert property (
    cmd_char && link.code == own_addr && eop_active
    |=> !s_reg.listener_flag)
    else $error("address won over end of program");

  lockout_holds_remote_a: assert property (
    s_reg.remote && s_reg.lockout && s_reg.lrs_s2 && !ren_high
    |=> REMOTE_LAMP)
    else $error("locked out unit left remote");

  unlisten_cover_c: cover property ($fell(s_reg.listener_flag));
  addr_cover_c: cover property ($rose(s_reg.listener_flag));
  arm_a_cover_c: cover property (s_reg.pend_valid && s_reg.pend_a ##1
    $changed(RELAY_TO_A));
  lockout_cover_c: cover property ($rose(s_reg.lockout));
  return_cover_c: cover property ($fell(s_reg.remote));

endmodule : bus_relay_command_decoder

// ===== src/char_handshake.sv
// Three-wire character handshake and pin synchronisers for the bus lines.
// Assumes the controller sets data lines before raising data valid.
`timescale 1ns/100ps

module char_handshake
  import relay_decoder_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       dav_pin,
  input  wire logic [6:0] dio_pin,
  input  wire logic       mre_pin,
  output logic            ready_for_data_line,
  output logic            dac,
  char_link_if.src        link
);
  import relay_decoder_pkg::*;

  hs_s s_reg;
  hs_s s_next;

  // ****************************************************************
  // Handshake sequencing.
  // ****************************************************************
  // Data and valid pass equal synchroniser depth, so a code that was
  // settled before valid rose is settled when valid is seen.
  always_comb begin
    s_next        = s_reg;
    s_next.dav_s1 = dav_pin;
    s_next.dav_s2 = s_reg.dav_s1;
    s_next.dio_s1 = dio_pin;
    s_next.dio_s2 = s_reg.dio_s1;
    s_next.mre_s1 = mre_pin;
    s_next.mre_s2 = s_reg.mre_s1;
    s_next.valid  = 1'b0;
    unique case (s_reg.state)
      HS_IDLE: begin
        if (s_reg.dav_s2) begin
          s_next.code      = s_reg.dio_s2;
          s_next.data_mode = s_reg.mre_s2;
          s_next.valid     = 1'b1;
          s_next.ready_for_data_line       = 1'b0;
          s_next.dac       = 1'b1;
          s_next.state     = HS_HELD;
        end
      end
      HS_HELD: begin
        if (!s_reg.dav_s2) begin
          s_next.dac   = 1'b0;
          s_next.state = HS_RELEASE;
        end
      end
      HS_RELEASE: begin
        s_next.ready_for_data_line   = 1'b1;
        s_next.state = HS_IDLE;
      end
      default: begin
        s_next.ready_for_data_line   = 1'b1;
        s_next.dac   = 1'b0;
        s_next.state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_reg       <= '0;
      s_reg.state <= HS_IDLE;
      s_reg.ready_for_data_line   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ready_for_data_line            = s_reg.ready_for_data_line;
  assign dac            = s_reg.dac;
  assign link.valid     = s_reg.valid;
  assign link.code      = s_reg.code;
  assign link.data_mode = s_reg.data_mode;

  hs_ready_excl_a: assert property (@(posedge clock) disable iff (!arst_n)
    !(s_reg.ready_for_data_line && s_reg.dac))
    else $error("ready and accepted both high");

  hs_one_char_a: assert property (@(posedge clock) disable iff (!arst_n)
    s_reg.valid |=> !s_reg.valid && s_reg.dac)
    else $error("character strobe not single");

endmodule : char_handshake

// ===== tb/bus_controller_model.sv
// Behavioural bus controller that hands characters to the decoder.
// Assumes the decoder paces each transfer with its ready and accepted lines.
`timescale 1ns/100ps

module bus_controller_model (
  input  wire logic       clock,
  input  wire logic       ready_for_data_line,
  input  wire logic       dac,
  output logic [6:0]      dio,
  output logic            dav,
  output logic            command_mode_line
);
  initial begin
    dio = 7'h00;
    dav = 1'b0;
    command_mode_line = 1'b0;
  end

  // Released lines carry the inverted code so a stale value is never read.
  task automatic send(input logic [6:0] code, input logic mode,
                      output bit ok);
    int n;
    ok = 1'b1;
    n = 0;
    @(posedge clock);
    dio <= code;
    command_mode_line <= mode;
    repeat (3) @(posedge clock);
    dav <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (dac !== 1'b1 && n < 60);
    dav <= 1'b0;
    dio <= ~code;
    do begin
      @(posedge clock);
      n++;
    end while (ready_for_data_line !== 1'b1 && n < 120);
    if (n >= 120) ok = 1'b0;
  endtask : send
endmodule : bus_controller_model

// ===== tb/tb.sv
// Self-checking bench for the bus relay command decoder.
// Assumes the controller model beside it and a zero-wait AHB-Lite slave.
`timescale 1ns/100ps
`include "relay_decoder_params.svh"

module tb;
  import relay_decoder_pkg::*;
  logic        CLOCK, ARST_N, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [6:0]  DATA_LINES;
  logic        DATA_VALID, READY_FOR_DATA_LINE, DATA_ACCEPTED;
  logic        COMMAND_MODE_LINE, REMOTE_ENABLE, END_OF_PROGRAM_LINE_N;
  logic        LOCAL_RESET_SWITCH, REMOTE_LAMP;
  logic [4:0]  ADDRESS_SWITCHES, adr;
  relay_t      PANEL_SWITCHES, RELAY_TO_A, RELAY_LAMPS, relay;
  logic        listen, remote, lockout, armed, arm_a, en;
  logic [31:0] d;
  int          cnt, n_errors, check_count, seed, k;
  logic [6:0]  tab [10] = '{7'h41, 7'h42, 7'h31, 7'h32, 7'h33, 7'h34,
                            7'h35, 7'h36, 7'h3f, 7'h11};

  bus_relay_command_decoder bus_relay_command_decoder_i (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .DATA_LINES(DATA_LINES), .DATA_VALID(DATA_VALID),
    .READY_FOR_DATA_LINE(READY_FOR_DATA_LINE),
    .DATA_ACCEPTED(DATA_ACCEPTED), .COMMAND_MODE_LINE(COMMAND_MODE_LINE),
    .REMOTE_ENABLE(REMOTE_ENABLE),
    .END_OF_PROGRAM_LINE_N(END_OF_PROGRAM_LINE_N),
    .LOCAL_RESET_SWITCH(LOCAL_RESET_SWITCH),
    .ADDRESS_SWITCHES(ADDRESS_SWITCHES), .PANEL_SWITCHES(PANEL_SWITCHES),
    .RELAY_TO_A(RELAY_TO_A), .RELAY_LAMPS(RELAY_LAMPS),
    .REMOTE_LAMP(REMOTE_LAMP));

  bus_controller_model ctl_i (
    .clock(CLOCK), .ready_for_data_line(READY_FOR_DATA_LINE), .dac(DATA_ACCEPTED),
    .dio(DATA_LINES), .dav(DATA_VALID), .command_mode_line(COMMAND_MODE_LINE));

  always #12.5 CLOCK = ~CLOCK;

  // ****************************************************************
  // Bus and comparison tasks
  // ****************************************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLOCK);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    check(32'(HRESP), 32'h0, "response");
  endtask : ahb

  task automatic cmp_all;
    logic [31:0] st;
    check(32'(RELAY_TO_A), 32'(relay), "relays");
    check(32'(RELAY_LAMPS), 32'(relay), "lamps");
    check(32'(REMOTE_LAMP), 32'(remote), "remote lamp");
    ahb(`OFS_STATUS, 1'b0, 32'h0, st);
    st[4] = st[4] & armed;
    check(st, {18'h0, relay, 3'h0, arm_a & armed, armed, lockout, remote,
               listen}, "status");
    ahb(`OFS_COUNT, 1'b0, 32'h0, st);
    check(st, 32'(cnt[15:0]), "count");
  endtask : cmp_all

  // ****************************************************************
  // Behavioural model of the decoder, updated per character and pin
  // ****************************************************************
  task automatic put(input logic [6:0] c, input logic m);
    bit ok;
    ctl_i.send(c, m, ok);
    check(32'(ok), 32'h1, "handshake stalled");
    cnt++;
    if (en && !m) begin
      if (c == {`CODE_ADDR_TOP, adr}) begin
        if (!REMOTE_ENABLE) {listen, remote} = 2'b11;
      end else if (c == `CODE_LOCKOUT) begin
        if (!REMOTE_ENABLE) lockout = 1'b1;
      end else listen = 1'b0;
    end else if (en && listen && remote) begin
      if (c == `CODE_STATE_A || c == `CODE_STATE_B) begin
        armed = 1'b1;
        arm_a = (c == `CODE_STATE_A);
      end else if (armed && c >= `CODE_SEL_FIRST && c <= `CODE_SEL_LAST)
        relay[c - `CODE_SEL_FIRST] = arm_a;
    end
    if (!remote) relay = PANEL_SWITCHES;
    cmp_all();
  endtask : put

  task automatic pins(input logic ren, eop, lrs, input relay_t pnl);
    @(posedge CLOCK);
    REMOTE_ENABLE         <= ren;
    END_OF_PROGRAM_LINE_N <= eop;
    LOCAL_RESET_SWITCH    <= lrs;
    PANEL_SWITCHES        <= pnl;
    repeat (5) @(posedge CLOCK);
    if (ren) begin
      remote  = 1'b0;
      lockout = 1'b0;
      armed   = 1'b0;
    end
    if (!eop) listen = 1'b0;
    if (lrs && !lockout) begin
      remote = 1'b0;
      armed  = 1'b0;
    end
    if (!remote) relay = pnl;
    cmp_all();
  endtask : pins

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end

  initial begin
    seed = 32'h3934;
    {CLOCK, ARST_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    HSIZE = 3'h2;
    {END_OF_PROGRAM_LINE_N, REMOTE_ENABLE, LOCAL_RESET_SWITCH} = 3'b110;
    adr = 5'((($random(seed)) & 32'hffff) % 31);
    ADDRESS_SWITCHES = adr;
    PANEL_SWITCHES = 6'($random(seed));
    {listen, remote, lockout, armed, arm_a, relay, cnt} = '0;
    en = 1'b1;
    repeat (16) @(posedge CLOCK);
    ARST_N <= 1'b1;
    pins(1'b1, 1'b1, 1'b0, 6'($random(seed)));
    ahb(`OFS_CONTROL, 1'b0, 32'h0, d);
    check(d, 32'h1, "control reset");
    ahb(8'h0c, 1'b1, 32'hffffffff, d);
    ahb(8'h0c, 1'b0, 32'h0, d);
    check(d, 32'h0, "unmapped");
    put(`CODE_UNLISTEN, 1'b0);
    pins(1'b0, 1'b1, 1'b0, PANEL_SWITCHES);
    put({`CODE_ADDR_TOP, adr}, 1'b0);
    pins(1'b0, 1'b1, 1'b0, ~PANEL_SWITCHES);
    put(`CODE_LOCKOUT, 1'b0);
    pins(1'b0, 1'b1, 1'b1, PANEL_SWITCHES);
    pins(1'b0, 1'b1, 1'b0, PANEL_SWITCHES);
    put(`CODE_SEL_FIRST, 1'b1);
    for (k = 0; k < 2; k++) begin
      put(k ? `CODE_STATE_B : `CODE_STATE_A, 1'b1);
      for (int i = 0; i < 6; i++) put(`CODE_SEL_FIRST + 7'(i), 1'b1);
    end
    put(`CODE_STATE_A, 1'b1);
    put(7'h33, 1'b1);
    put(7'h37, 1'b1);
    put({`CODE_ADDR_TOP, adr ^ 5'h01}, 1'b0);
    put(`CODE_SEL_LAST, 1'b1);
    put({`CODE_ADDR_TOP, adr}, 1'b0);
    pins(1'b0, 1'b0, 1'b0, PANEL_SWITCHES);
    pins(1'b0, 1'b1, 1'b0, PANEL_SWITCHES);
    put(`CODE_SEL_FIRST, 1'b1);
    pins(1'b1, 1'b1, 1'b0, 6'($random(seed)));
    put({`CODE_ADDR_TOP, adr}, 1'b0);
    put(`CODE_LOCKOUT, 1'b0);
    pins(1'b0, 1'b1, 1'b0, PANEL_SWITCHES);
    put({`CODE_ADDR_TOP, adr}, 1'b0);
    pins(1'b0, 1'b1, 1'b1, PANEL_SWITCHES);
    pins(1'b0, 1'b1, 1'b0, 6'($random(seed)));
    for (int i = 0; i < 60; i++) begin
      k = (($random(seed)) & 32'hff) % 11;
      put(k == 10 ? {`CODE_ADDR_TOP, adr} : tab[k],
          (k < 8) ^ ((($random(seed)) & 7) == 0));
    end
    ahb(`OFS_CONTROL, 1'b1, 32'h0, d);
    en = 1'b0;
    put(`CODE_UNLISTEN, 1'b0);
    ahb(`OFS_COUNT, 1'b1, $random(seed), d);
    cnt = 0;
    ahb(`OFS_CONTROL, 1'b1, 32'h1, d);
    en = 1'b1;
    put(`CODE_UNLISTEN, 1'b0);
    end_sim();
  end
endmodule : tb
